// ==== dv/ahm_alu_mult_assertions.sv ====
// Port checker for the ALU and multiplier block
`timescale 1ns/1ns
`default_nettype none
module ahm_alu_mult_chk
    import ahm_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic instrValid,
    input wire ahm_pkg::ahm_instr_type instr,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] workingReg,
    input wire logic [15:0] productOut,
    input wire logic [3:0] flagsOut
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [7:0] ph;
    logic [7:0] df;
    logic go;
    assign ph = productOut[15:8];
    assign df = ph - workingReg;
    assign go = instrValid && !regWrite;
    sequence s_mul; go && instr.op == OP_MUL; endsequence
    sequence s_sub; go && instr.op == OP_SUB && instr.toFile
        && instr.toProdHigh; endsequence
    property p_mul_flags; s_mul |=> $stable(flagsOut); endproperty
    a_mul_flags: assert property (p_mul_flags)
        else $error("mul flags");
    property p_mul_w; s_mul |=> $stable(workingReg); endproperty
    a_mul_w: assert property (p_mul_w)
        else $error("mul w");
    property p_sub_ph; s_sub |=> ph == $past(df)
        && flagsOut[FLAG_CARRY] == $past(ph >= workingReg); endproperty
    a_sub_ph: assert property (p_sub_ph)
        else $error("sub high");
    property p_sub_half; s_sub |=> flagsOut[FLAG_ZERO] == (ph == 8'h00)
        && flagsOut[FLAG_HALF] == $past(ph[3:0] >= workingReg[3:0]);
    endproperty
    a_sub_half: assert property (p_sub_half)
        else $error("sub half");
    property p_sub_range; s_sub |=> flagsOut[FLAG_RANGE]
        == $past(ph[7] != workingReg[7] && df[7] != ph[7]); endproperty
    a_sub_range: assert property (p_sub_range)
        else $error("range");
    property p_hold; !instrValid && !regWrite |=> $stable(productOut);
    endproperty
    a_hold: assert property (p_hold)
        else $error("prod hold");
    property p_rd_high; regRead && regAddr == ADDR_PROD_HIGH
        |=> regRdata == $past(ph); endproperty
    a_rd_high: assert property (p_rd_high)
        else $error("rd high");
    property p_none; go && instr.op == OP_NONE
        |=> $stable({workingReg, productOut, flagsOut}); endproperty
    a_none: assert property (p_none)
        else $error("none op");
endmodule : ahm_alu_mult_chk
`default_nettype wire

// ==== dv/ahm_alu_mult_tb.sv ====
// Self-checking bench for the ALU and multiplier block
`timescale 1ns/1ns
`default_nettype none
module ahm_alu_mult_tb;
    import ahm_pkg::*;
    logic mclk, arst_n, instrValid, regWrite, regRead;
    ahm_instr_type instr;
    logic [3:0] regAddr, flagsOut;
    logic [7:0] regWdata, regRdata, workingReg, a, b, f;
    logic [15:0] productOut, p;
    logic [11:0] e;
    logic [15:0] expQ[$];
    logic rdLast = 1'b0;
    logic [31:0] seed = 32'h00003fd3;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    ahm_op_type o;
    ahm_op_type ops[10] = '{OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_OR,
        OP_XOR, OP_RLC, OP_RRC, OP_MOVF, OP_MUL};
    ahm_alu_mult DUT (.mclk, .arst_n, .instrValid, .instr, .regAddr,
        .regWdata, .regWrite, .regRead, .regRdata, .workingReg,
        .productOut, .flagsOut);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [11:0] model(ahm_op_type op, logic [7:0] w,
        logic [7:0] v, logic [3:0] fl);
        logic [8:0] s;
        logic [7:0] r;
        r = w;
        case (op)
            OP_ADD: begin
                s = {1'b0, w} + {1'b0, v};
                r = s[7:0];
                fl[0] = s[8];
                fl[1] = ({1'b0, w[3:0]} + {1'b0, v[3:0]}) > 5'h0f;
                fl[3] = w[7] == v[7] && r[7] != w[7];
            end
            OP_SUB: begin
                s = {1'b0, v} - {1'b0, w};
                r = s[7:0];
                fl[0] = ~s[8];
                fl[1] = v[3:0] >= w[3:0];
                fl[3] = v[7] != w[7] && r[7] != v[7];
            end
            OP_AND: r = w & v;
            OP_OR: r = w | v;
            OP_XOR: r = w ^ v;
            OP_RLC: begin
                r = {v[6:0], fl[0]};
                fl[0] = v[7];
            end
            OP_RRC: begin
                r = {fl[0], v[7:1]};
                fl[0] = v[0];
            end
            OP_MOVF: r = v;
            default: r = w;
        endcase
        if (op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_RLC,
                OP_RRC}) begin
            fl[2] = r == 8'h00;
        end
        return {fl, r};
    endfunction : model
    task automatic drive(logic w, logic r, logic [3:0] ad, logic [7:0] d,
        logic v, ahm_instr_type i);
        regWrite <= w;
        regRead <= r;
        regAddr <= ad;
        regWdata <= d;
        instrValid <= v;
        instr <= i;
        @(posedge mclk);
    endtask : drive
    task automatic wr(logic [3:0] ad, logic [7:0] d);
        drive(1'b1, 1'b0, ad, d, 1'b0, '0);
    endtask : wr
    task automatic rd(logic [3:0] ad, logic [7:0] m, logic [7:0] x);
        expQ.push_back({m, x});
        drive(1'b0, 1'b1, ad, 8'h00, 1'b0, '0);
    endtask : rd
    task automatic ex(ahm_op_type op, logic [2:0] k, logic t);
        drive(1'b0, 1'b0, 4'h0, 8'h00, 1'b1, '{op, k, t, t});
    endtask : ex
    task automatic chk(logic [15:0] me);
        checked++;
        if ((regRdata & me[15:8]) !== me[7:0]) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, regRdata, me[7:0]);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // Read monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        rdLast <= regRead;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    always @(negedge mclk) begin
        if (rdLast === 1'b1) begin
            chk(expQ.pop_front());
        end
    end
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        {regWrite, regRead, instrValid, regAddr, regWdata} = '0;
        instr = '0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd(ADDR_PROD_HIGH, 8'hff, 8'h00);
        for (int n = 0; n < 70; n++) begin
            o = ops[n % 10];
            a = rnd();
            b = rnd();
            f = rnd();
            if (n < 2) begin
                o = OP_ADD;
                a = n ? 8'h7f : 8'hff;
                b = 8'h01;
            end else if (n == 9) begin
                // Both signs set: both corrections of the high byte run
                a = 8'h9c;
                b = 8'hc5;
            end
            wr(ADDR_WORKING, a);
            wr(ADDR_FILE0 + {1'b0, 3'(n % 3)}, b);
            wr(ADDR_FLAGS, {4'h0, f[3:0]});
            wr(4'hf, rnd());
            ex(o, 3'(n % 3), 1'b0);
            e = model(o, a, b, f[3:0]);
            rd(ADDR_WORKING, 8'hff, e[7:0]);
            rd(ADDR_FLAGS, 8'h0f, {4'h0, e[11:8]});
            if (n > 39 && !(o inside {OP_NONE, OP_MUL})) begin
                // Same operation again, result to the file register
                drive(1'b0, 1'b0, 4'h0, 8'h00, 1'b1,
                    '{o, 3'(n % 3), 1'b1, 1'b0});
                e = model(o, e[7:0], b, e[11:8]);
                rd(ADDR_FILE0 + {1'b0, 3'(n % 3)}, 8'hff, e[7:0]);
            end
            if (o == OP_MUL) begin
                p = a * b;
                rd(ADDR_PROD_LOW, 8'hff, p[7:0]);
                rd(ADDR_PROD_HIGH, 8'hff, p[15:8]);
                if (b[7]) ex(OP_SUB, 3'(n % 3), 1'b1);
                wr(ADDR_WORKING, b);
                if (a[7]) ex(OP_SUB, 3'(n % 3), 1'b1);
                rd(ADDR_PROD_LOW, 8'hff, p[7:0]);
                p = $signed(a) * $signed(b);
                rd(ADDR_PROD_HIGH, 8'hff, p[15:8]);
            end
        end
        drive(1'b0, 1'b0, 4'h0, 8'h00, 1'b0, '0);
        repeat (2) @(posedge mclk);
        report_and_stop();
    end
endmodule : ahm_alu_mult_tb
bind ahm_alu_mult ahm_alu_mult_chk u_chk (.mclk, .arst_n, .instrValid,
    .instr, .regAddr, .regWrite, .regRead, .regRdata, .workingReg,
    .productOut, .flagsOut);
`default_nettype wire

// ==== include/ahm_pkg.sv ====
// Package for the ALU and hardware multiplier datapath
package ahm_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_WORKING = 4'h0;
    localparam logic [3:0] ADDR_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_PROD_LOW = 4'h2;
    localparam logic [3:0] ADDR_PROD_HIGH = 4'h3;
    localparam logic [3:0] ADDR_FILE0 = 4'h4;
    localparam int FILE_COUNT = 8;

    // ------------------------------------------------------------
    // Flag bit positions and reset values
    // ------------------------------------------------------------
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_HALF = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_RANGE = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_ADD = 4'b0001,
        OP_SUB = 4'b0010,
        OP_AND = 4'b0011,
        OP_OR = 4'b0100,
        OP_XOR = 4'b0101,
        OP_RLC = 4'b0110,
        OP_RRC = 4'b0111,
        OP_MUL = 4'b1000,
        OP_MOVF = 4'b1001
    } ahm_op_type;

    typedef struct packed {
        ahm_op_type op;
        logic [2:0] fileSel;
        logic toFile;
        logic toProdHigh;
    } ahm_instr_type;

    typedef struct packed {
        logic [7:0] result;
        logic carry;
        logic half;
        logic zero;
        logic range;
    } ahm_alu_out_type;

endpackage : ahm_pkg

// ==== verilog/ahm_alu_mult.sv ====
// ALU with flags and single-cycle 8 x 8 hardware multiplier
//
// Functional notes
// [RULE1] Unsigned 8 x 8 full 16-bit product
// [RULE2] Multiply completes in one instruction cycle
// [RULE3] Product high and low bytes written
// [RULE4] Multiply leaves all ALU flags unchanged
// [RULE5] Operands: working register and file register
// [RULE6] Product high byte usable subtract destination
// [RULE7] Product bytes hold until overwritten; readable
// [RULE8] 8-bit add, subtract, shift, logic operations
// [RULE9] Instructions update carry, half, zero, range
// [RULE10] Range flag from bits 6 and 7
// [RULE11] Subtract carries are inverted borrows
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module ahm_alu_mult
    import ahm_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic instrValid,
    input wire ahm_pkg::ahm_instr_type instr,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    output logic [7:0] workingReg,
    output logic [15:0] productOut,
    output logic [3:0] flagsOut
);
    import ahm_pkg::*;

    logic [7:0] working_register_reg;
    logic [7:0] product_low_byte_reg;
    logic [7:0] product_high_byte_reg;
    logic [3:0] alu_flags_register_reg;
    logic [7:0] fileReg [FILE_COUNT];
    logic [7:0] rdata_reg;
    logic [7:0] operandA;
    logic [7:0] operandB;
    logic [15:0] product;
    logic [8:0] sum;
    logic [4:0] halfSum;
    ahm_alu_out_type alu;
    logic flagWrite;

    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------
    always_comb begin
        operandA = working_register_reg; // [RULE5]
        if (instr.toProdHigh) begin
            operandB = product_high_byte_reg; // [RULE6]
        end else begin
            operandB = fileReg[instr.fileSel]; // [RULE5]
        end
    end

    // Unsigned, zero extended, combinational so result lands same cycle
    assign product = {8'h00, operandA} * {8'h00, operandB}; // [RULE1] [RULE2]

    // ------------------------------------------------------------
    // ALU
    // ------------------------------------------------------------
    always_comb begin
        sum = 9'h000;
        halfSum = 5'h00;
        alu.result = operandB;
        alu.carry = alu_flags_register_reg[FLAG_CARRY];
        alu.half = alu_flags_register_reg[FLAG_HALF];
        alu.range = alu_flags_register_reg[FLAG_RANGE];
        flagWrite = 1'b0;
        unique case (instr.op)
            OP_ADD: begin
                sum = {1'b0, operandB} + {1'b0, operandA}; // [RULE8]
                halfSum = {1'b0, operandB[3:0]} + {1'b0, operandA[3:0]};
                alu.result = sum[7:0];
                alu.carry = sum[8];
                alu.half = halfSum[4];
                alu.range = (operandA[7] == operandB[7])
                    && (sum[7] != operandA[7]); // [RULE10]
                flagWrite = 1'b1; // [RULE9]
            end
            OP_SUB: begin
                // f - w as f + ~w + 1: carry out is not-borrow
                sum = {1'b0, operandB} + {1'b0, ~operandA} + 9'h001; // [RULE8]
                halfSum = {1'b0, operandB[3:0]} + {1'b0, ~operandA[3:0]}
                    + 5'h01;
                alu.result = sum[7:0];
                alu.carry = sum[8]; // [RULE11]
                alu.half = halfSum[4]; // [RULE11]
                alu.range = (operandA[7] != operandB[7])
                    && (sum[7] != operandB[7]); // [RULE10]
                flagWrite = 1'b1; // [RULE9]
            end
            OP_AND: begin
                alu.result = operandA & operandB; // [RULE8]
                flagWrite = 1'b1;
            end
            OP_OR: begin
                alu.result = operandA | operandB;
                flagWrite = 1'b1;
            end
            OP_XOR: begin
                alu.result = operandA ^ operandB;
                flagWrite = 1'b1;
            end
            OP_RLC: begin
                alu.result = {operandB[6:0],
                    alu_flags_register_reg[FLAG_CARRY]}; // [RULE8]
                alu.carry = operandB[7];
                flagWrite = 1'b1;
            end
            OP_RRC: begin
                alu.result = {alu_flags_register_reg[FLAG_CARRY],
                    operandB[7:1]};
                alu.carry = operandB[0];
                flagWrite = 1'b1;
            end
            OP_MOVF: begin
                alu.result = operandB;
            end
            OP_MUL: begin
                alu.result = operandB;
            end
            OP_NONE: begin
                alu.result = operandB;
            end
            default: begin
                alu.result = operandB;
            end
        endcase
        alu.zero = (alu.result == 8'h00); // [RULE9]
    end

    // ------------------------------------------------------------
    // Flags register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alu_flags_register_reg <= RESET_BYTE[3:0];
        end else if (regWrite && regAddr == ADDR_FLAGS) begin
            alu_flags_register_reg <= regWdata[3:0];
        end else if (instrValid && flagWrite) begin
            // Multiply never sets flagWrite
            alu_flags_register_reg[FLAG_CARRY] <= alu.carry; // [RULE9] [RULE4]
            alu_flags_register_reg[FLAG_HALF] <= alu.half;
            alu_flags_register_reg[FLAG_ZERO] <= alu.zero;
            alu_flags_register_reg[FLAG_RANGE] <= alu.range;
        end
    end

    // ------------------------------------------------------------
    // Product register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            product_low_byte_reg <= RESET_BYTE;
            product_high_byte_reg <= RESET_BYTE;
        end else if (instrValid && instr.op == OP_MUL) begin
            product_high_byte_reg <= product[15:8]; // [RULE3] [RULE2]
            product_low_byte_reg <= product[7:0]; // [RULE3]
        end else if (instrValid && flagWrite && instr.toFile
                && instr.toProdHigh) begin
            product_high_byte_reg <= alu.result; // [RULE6]
        end else if (regWrite && regAddr == ADDR_PROD_LOW) begin
            product_low_byte_reg <= regWdata; // [RULE7]
        end else if (regWrite && regAddr == ADDR_PROD_HIGH) begin
            product_high_byte_reg <= regWdata; // [RULE7]
        end
    end

    // ------------------------------------------------------------
    // Working register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            working_register_reg <= RESET_BYTE;
        end else if (instrValid && instr.op != OP_MUL
                && instr.op != OP_NONE && !instr.toFile) begin
            working_register_reg <= alu.result;
        end else if (regWrite && regAddr == ADDR_WORKING) begin
            working_register_reg <= regWdata;
        end
    end

    // ------------------------------------------------------------
    // File registers
    // ------------------------------------------------------------
    for (genvar i = 0; i < FILE_COUNT; i++) begin : g_file
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                fileReg[i] <= RESET_BYTE;
            end else if (instrValid && instr.toFile && !instr.toProdHigh
                    && instr.op != OP_MUL && instr.op != OP_NONE
                    && instr.fileSel == 3'(i)) begin
                fileReg[i] <= alu.result;
            end else if (regWrite
                    && regAddr == ADDR_FILE0 + 4'(i)) begin
                fileReg[i] <= regWdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= RESET_BYTE;
        end else if (regRead) begin
            if (regAddr >= ADDR_FILE0) begin
                rdata_reg <= fileReg[3'(regAddr - ADDR_FILE0)];
            end else begin
                unique case (regAddr[1:0])
                    2'h0: rdata_reg <= working_register_reg;
                    2'h1: rdata_reg <= {4'h0, alu_flags_register_reg};
                    2'h2: rdata_reg <= product_low_byte_reg; // [RULE7]
                    2'h3: rdata_reg <= product_high_byte_reg; // [RULE7]
                endcase
            end
        end
    end

    assign regRdata = rdata_reg;
    assign workingReg = working_register_reg;
    assign productOut = {product_high_byte_reg, product_low_byte_reg};
    assign flagsOut = alu_flags_register_reg;

endmodule : ahm_alu_mult
`default_nettype wire
